// file: rtl/sched_pkg.sv
/*
  Constants, register map and carrier types for the produce transaction
  scheduler. Assumes a 10 MHz clock and a 12-bit shared memory buffer.
*/
// How it works
// - Trigger mode issues when the trigger byte differs from the last check.
// - Trigger bytes are compared only once per update-time interval.
// - Update time counts in 10 ms ticks.
// - Trigger byte address must lie in 0x200..0x3FF or 0x400..0xFFF.
// - Trigger address is ignored and unmonitored unless in trigger mode.
// - Cyclic mode issues once at every update-time interval.
// - Data-change mode issues at an interval only when its data area was written.
package sched_pkg;

  // Timing
  localparam int TICK_TIME_MS   = 10;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_CYCLES    = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // Sizes
  localparam int NUM_TXN        = 4;
  localparam int FIFO_DEPTH     = 4;
  localparam int BUF_ADDR_W     = 12;
  localparam int AXI_ADDR_W     = 8;

  // Update modes
  localparam logic [1:0] MODE_SINGLE  = 2'h0;
  localparam logic [1:0] MODE_CYCLIC  = 2'h1;
  localparam logic [1:0] MODE_DATA    = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;

  // Valid trigger address window
  localparam logic [BUF_ADDR_W-1:0] TRIG_ADDR_MIN = 12'h200;
  localparam logic [BUF_ADDR_W-1:0] TRIG_ADDR_MAX = 12'hFFF;

  // Register byte addresses
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_CFG_BASE = 8'h10;
  localparam int                    CFG_STRIDE   = 8;
  localparam int                    CFG_WORD1    = 4;

  // Field positions
  localparam int CTRL_RUN_BIT      = 0;
  localparam int CFG0_MODE_LSB     = 0;
  localparam int CFG0_TRIG_LSB     = 4;
  localparam int CFG0_TIME_LSB     = 16;
  localparam int CFG1_START_LSB    = 0;
  localparam int CFG1_LEN_LSB      = 16;
  localparam int STAT_PEND_LSB     = 0;
  localparam int STAT_CFGERR_LSB   = 8;
  localparam int STAT_DONE_LSB     = 16;
  localparam int STAT_RUN_BIT      = 24;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Shared memory buffer write, from the controller side
  typedef struct packed {
    logic                  we;
    logic [BUF_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } buf_wr_type;

  // Decoded per-transaction settings
  typedef struct packed {
    logic [1:0]            mode;
    logic [BUF_ADDR_W-1:0] trig_addr;
    logic [15:0]           upd_time;
    logic [BUF_ADDR_W-1:0] data_start;
    logic [BUF_ADDR_W:0]   data_len;
  } txn_cfg_type;

endpackage

// file: rtl/sched_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sched_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign level_o     = count_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q        <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule // sched_fifo
`default_nettype wire

// file: rtl/prod_sched.sv
/*
  Produce transaction scheduler: decides when each transaction is issued.
  Assumes a 10 MHz clock, an AXI4-Lite master for configuration, and a
  controller writing the shared buffer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module prod_sched
  import sched_pkg::*;
#(
  parameter int TICK_CNT = sched_pkg::TICK_CYCLES,
  parameter int N_TXN    = sched_pkg::NUM_TXN,
  parameter int Q_DEPTH  = sched_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                           CLK_I,
  input  wire logic                           NRST_I,
  // AXI4-Lite write address / data / response
  input  wire logic                           S_AXI_AWVALID_I,
  output logic                                S_AXI_AWREADY_O,
  input  wire logic [sched_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic [2:0]                     S_AXI_AWPROT_I,
  input  wire logic                           S_AXI_WVALID_I,
  output logic                                S_AXI_WREADY_O,
  input  wire logic [31:0]                    S_AXI_WDATA_I,
  input  wire logic [3:0]                     S_AXI_WSTRB_I,
  output logic                                S_AXI_BVALID_O,
  input  wire logic                           S_AXI_BREADY_I,
  output logic [1:0]                          S_AXI_BRESP_O,
  // AXI4-Lite read address / data
  input  wire logic                           S_AXI_ARVALID_I,
  output logic                                S_AXI_ARREADY_O,
  input  wire logic [sched_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic [2:0]                     S_AXI_ARPROT_I,
  output logic                                S_AXI_RVALID_O,
  input  wire logic                           S_AXI_RREADY_I,
  output logic [31:0]                         S_AXI_RDATA_O,
  output logic [1:0]                          S_AXI_RRESP_O,
  // Shared buffer writes from the controller
  input  wire sched_pkg::buf_wr_type          BUF_WR_I,
  // Issued transaction stream toward the sub-network
  output logic                                TXN_VALID_O,
  input  wire logic                           TXN_READY_I,
  output logic [7:0]                          TXN_INDEX_O
);
  import sched_pkg::*;

  localparam int TW = $clog2(TICK_CNT + 1);
  localparam int IW = (N_TXN > 1) ? $clog2(N_TXN) : 1;

  // ---------------- Register bus ----------------
  logic                  aw_full_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic                  w_full_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic [31:0]           ctrl_q;
  logic [31:0]           cfg0_q [N_TXN];
  logic [31:0]           cfg1_q [N_TXN];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  wire                  do_write = aw_full_q && w_full_q && !bvalid_q;
  wire                  ar_take  = S_AXI_ARVALID_I && !rvalid_q;
  wire [AXI_ADDR_W-1:0] wa_rel   = aw_addr_q - REG_CFG_BASE;
  wire [AXI_ADDR_W-1:0] ra_rel   = S_AXI_ARADDR_I - REG_CFG_BASE;
  wire [AXI_ADDR_W-1:0] w_idx    = wa_rel / AXI_ADDR_W'(CFG_STRIDE);
  wire [AXI_ADDR_W-1:0] r_idx    = ra_rel / AXI_ADDR_W'(CFG_STRIDE);
  wire                  w_hi     = wa_rel[2];
  wire                  r_hi     = ra_rel[2];
  wire                  w_is_ctrl = (aw_addr_q[AXI_ADDR_W-1:2] == REG_CTRL[AXI_ADDR_W-1:2]);
  wire                  w_is_stat = (aw_addr_q[AXI_ADDR_W-1:2] == REG_STATUS[AXI_ADDR_W-1:2]);
  wire                  w_is_cfg  = (aw_addr_q >= REG_CFG_BASE) && (w_idx < AXI_ADDR_W'(N_TXN));
  wire                  r_is_ctrl = (S_AXI_ARADDR_I[AXI_ADDR_W-1:2] == REG_CTRL[AXI_ADDR_W-1:2]);
  wire                  r_is_stat = (S_AXI_ARADDR_I[AXI_ADDR_W-1:2] == REG_STATUS[AXI_ADDR_W-1:2]);
  wire                  r_is_cfg  = (S_AXI_ARADDR_I >= REG_CFG_BASE)
                                    && (r_idx < AXI_ADDR_W'(N_TXN));
  wire                  run       = ctrl_q[CTRL_RUN_BIT];

  assign S_AXI_AWREADY_O = !aw_full_q && !bvalid_q;
  assign S_AXI_WREADY_O  = !w_full_q && !bvalid_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (w_is_ctrl || w_is_stat || w_is_cfg) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Software-written settings
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_q <= CTRL_RESET;
      for (int k = 0; k < N_TXN; k++) begin
        cfg0_q[k] <= CFG_RESET;
        cfg1_q[k] <= CFG_RESET;
      end
    end else if (do_write) begin
      if (w_is_ctrl) begin
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0001;
      end
      if (w_is_cfg && !w_hi) begin
        cfg0_q[w_idx[IW-1:0]] <= merge(cfg0_q[w_idx[IW-1:0]], w_data_q, w_strb_q);
      end
      if (w_is_cfg && w_hi) begin
        cfg1_q[w_idx[IW-1:0]] <= merge(cfg1_q[w_idx[IW-1:0]], w_data_q, w_strb_q);
      end
    end
  end

  // ---------------- Update-time tick ----------------
  logic [TW-1:0] div_q;
  wire           tick = run && (div_q == TW'(TICK_CNT - 1));

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_q <= '0;
    end else begin
      div_q <= (!run || tick) ? '0 : div_q + 1'b1;
    end
  end

  // ---------------- Per-transaction scheduling ----------------
  logic [N_TXN-1:0] pend_q;
  logic [N_TXN-1:0] done_q;
  logic [N_TXN-1:0] cfg_err;
  logic [N_TXN-1:0] grant;
  logic             q_in_ready;
  logic [IW-1:0]    grant_idx;

  assign grant = q_in_ready ? (pend_q & (~pend_q + 1'b1)) : '0;

  always_comb begin
    grant_idx = '0;
    for (int k = N_TXN - 1; k >= 0; k--) begin
      if (pend_q[k]) begin
        grant_idx = IW'(k);
      end
    end
  end

  for (genvar i = 0; i < N_TXN; i++) begin : g_txn
    txn_cfg_type   cfg;
    logic [15:0]   tcnt_q;
    logic [7:0]    trig_cur_q;
    logic [7:0]    trig_seen_q;
    logic          dirty_q;

    assign cfg.mode       = cfg0_q[i][CFG0_MODE_LSB +: 2];
    assign cfg.trig_addr  = cfg0_q[i][CFG0_TRIG_LSB +: BUF_ADDR_W];
    assign cfg.upd_time   = cfg0_q[i][CFG0_TIME_LSB +: 16];
    assign cfg.data_start = cfg1_q[i][CFG1_START_LSB +: BUF_ADDR_W];
    assign cfg.data_len   = cfg1_q[i][CFG1_LEN_LSB +: BUF_ADDR_W+1];

    wire is_trig  = (cfg.mode == MODE_TRIGGER);
    wire trig_ok  = (cfg.trig_addr >= TRIG_ADDR_MIN) && (cfg.trig_addr <= TRIG_ADDR_MAX);
    wire [15:0] last = (cfg.upd_time == '0) ? 16'h0000 : cfg.upd_time - 16'h0001;
    wire due      = tick && (tcnt_q >= last);
    wire trig_hit = BUF_WR_I.we && is_trig && trig_ok
                    && (BUF_WR_I.addr == cfg.trig_addr);
    wire [BUF_ADDR_W:0] rel = {1'b0, BUF_WR_I.addr} - {1'b0, cfg.data_start};
    wire data_hit = BUF_WR_I.we && (cfg.mode == MODE_DATA)
                    && (BUF_WR_I.addr >= cfg.data_start) && (rel < cfg.data_len);
    wire fire = run && (((cfg.mode == MODE_SINGLE) && !done_q[i])
                || ((cfg.mode == MODE_CYCLIC) && due)
                || ((cfg.mode == MODE_DATA) && due && dirty_q)
                || (is_trig && trig_ok && due && (trig_cur_q != trig_seen_q)));

    assign cfg_err[i] = is_trig && !trig_ok;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        tcnt_q      <= '0;
        trig_cur_q  <= '0;
        trig_seen_q <= '0;
        dirty_q     <= 1'b0;
        done_q[i]   <= 1'b0;
        pend_q[i]   <= 1'b0;
      end else begin
        if (!run || due) begin
          tcnt_q <= '0;
        end else if (tick) begin
          tcnt_q <= tcnt_q + 16'h0001;
        end
        if (trig_hit) begin
          trig_cur_q <= BUF_WR_I.data;
        end
        if (due && is_trig) begin
          trig_seen_q <= trig_cur_q;
        end
        dirty_q   <= data_hit || (dirty_q && !due);
        done_q[i] <= done_q[i] || (fire && (cfg.mode == MODE_SINGLE));
        pend_q[i] <= fire || (pend_q[i] && !grant[i]);
      end
    end
  end

  // ---------------- Issue queue ----------------
  logic [7:0] q_out_data;

  sched_fifo #(
    .WIDTH (8),
    .DEPTH (Q_DEPTH)
  ) u_queue (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (|pend_q),
    .in_ready_o  (q_in_ready),
    .in_data_i   (8'(grant_idx)),
    .out_valid_o (TXN_VALID_O),
    .out_ready_i (TXN_READY_I),
    .out_data_o  (q_out_data),
    .level_o     ()
  );

  assign TXN_INDEX_O = q_out_data;

  // ---------------- Read path ----------------
  logic [31:0] status_word;
  logic [31:0] rd_word;

  always_comb begin
    status_word = '0;
    status_word[STAT_PEND_LSB +: N_TXN]   = pend_q;
    status_word[STAT_CFGERR_LSB +: N_TXN] = cfg_err;
    status_word[STAT_DONE_LSB +: N_TXN]   = done_q;
    status_word[STAT_RUN_BIT]             = run;
  end

  assign rd_word = r_is_ctrl ? ctrl_q
                 : r_is_stat ? status_word
                 : !r_is_cfg ? 32'h0000_0000
                 : r_hi      ? cfg1_q[r_idx[IW-1:0]]
                 :             cfg0_q[r_idx[IW-1:0]];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (r_is_ctrl || r_is_stat || r_is_cfg) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // prod_sched
`default_nettype wire

// file: testbench/sched_properties.sv
/*
  Port checker for the produce scheduler: bus answers and stream hold.
  Assumes it is bound into prod_sched and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sched_properties
  import sched_pkg::*;
#(
  parameter int N_TXN = 4
) (
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       NRST_I,
  // Register bus
  input wire logic       S_AXI_AWVALID_I,
  input wire logic       S_AXI_AWREADY_O,
  input wire logic       S_AXI_WVALID_I,
  input wire logic       S_AXI_WREADY_O,
  input wire logic       S_AXI_BVALID_O,
  input wire logic       S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic       S_AXI_ARVALID_I,
  input wire logic       S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic       S_AXI_RVALID_O,
  input wire logic       S_AXI_RREADY_I,
  input wire logic [1:0] S_AXI_RRESP_O,
  // Issue stream
  input wire logic       TXN_VALID_O,
  input wire logic       TXN_READY_I,
  input wire logic [7:0] TXN_INDEX_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire mapped = (S_AXI_ARADDR_I[1:0] == 2'h0) && ((S_AXI_ARADDR_I < 8'h08) ||
    ((S_AXI_ARADDR_I >= 8'h10) && (int'(S_AXI_ARADDR_I) < 16 + 8 * N_TXN)));
  sequence wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  a_wr_answer: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID_O)
    else $error("write not answered");
  a_wr_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while answering");
  a_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
  a_rd_answer: assert property (rd_taken |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
    else $error("read not answered");
  a_rd_decerr: assert property (rd_taken ##0 !mapped |=> S_AXI_RRESP_O == RESP_DECERR)
    else $error("unmapped read not refused");
  a_rd_okay: assert property (rd_taken ##0 mapped |=> S_AXI_RRESP_O == RESP_OKAY)
    else $error("mapped read refused");
  a_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RRESP_O)) else $error("read answer dropped");
  a_txn_hold: assert property (TXN_VALID_O && !TXN_READY_I
    |=> TXN_VALID_O && $stable(TXN_INDEX_O)) else $error("stalled issue changed");
  a_txn_index: assert property (TXN_VALID_O |-> int'(TXN_INDEX_O) < N_TXN)
    else $error("issue index out of range");
endmodule // sched_properties
bind prod_sched sched_properties #(.N_TXN(N_TXN)) chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RRESP_O(S_AXI_RRESP_O), .TXN_VALID_O(TXN_VALID_O),
  .TXN_READY_I(TXN_READY_I), .TXN_INDEX_O(TXN_INDEX_O));
`default_nettype wire

// file: testbench/ctl_model.sv
/*
  Control system model: writes bytes of the shared buffer.
  Assumes the scheduler takes one write per rising edge where we is high.
*/
`timescale 1ns/1ps
`default_nettype none
module ctl_model
  import sched_pkg::*;
(
  // Clock
  input  wire logic                 clk_i,
  // Buffer writes
  output var sched_pkg::buf_wr_type buf_wr_o
);
  initial buf_wr_o = '0;
  // Idle cycle shows inverted lines, never the last value
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    buf_wr_o <= '{we: 1'b1, addr: a, data: d};
    @(posedge clk_i);
    buf_wr_o <= '{we: 1'b0, addr: ~a, data: ~d};
    @(posedge clk_i);
  endtask
  // Data area first, then the trigger increment
  task automatic post(input logic [11:0] da, input logic [7:0] d,
                      input logic [11:0] ta, input logic [7:0] tv);
    put(da, d);
    put(ta, tv);
  endtask
endmodule // ctl_model
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Self-checking bench for prod_sched with a short tick.
  Assumes the checker is bound and ctl_model drives the buffer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sched_pkg::*;
  localparam int TK = 10;
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, trdy = 1'b1, awr, wr, bv, arr, rv, tv;
  logic [7:0] awa = 8'h00, ara = 8'h00, idx;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] br, rr;
  buf_wr_type bw;
  int miscompares = 0, tests_run = 0, cyc = 0, last0 = 0, gap0 = 0;
  int cnt [4];
  logic [7:0] log_q [$];
  always #50 clk = ~clk;
  ctl_model ctl (.clk_i(clk), .buf_wr_o(bw));
  prod_sched #(.TICK_CNT(TK)) DUT (.CLK_I(clk), .NRST_I(nrst),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rr), .BUF_WR_I(bw), .TXN_VALID_O(tv), .TXN_READY_I(trdy),
    .TXN_INDEX_O(idx));
  // Log every issue taken by the consumer
  always @(posedge clk) begin
    cyc++;
    if (tv === 1'b1 && trdy === 1'b1 && idx < 8'h04) begin
      cnt[idx]++;
      log_q.push_back(idx);
      if (idx === 8'h00) begin
        gap0 = cyc - last0;
        last0 = cyc;
      end
    end
  end
  always @(posedge clk) begin
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic clr();
    log_q.delete();
    foreach (cnt[i]) cnt[i] = 0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    bit da, dw;
    da = 0;
    dw = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(da && dw)) begin
      @(posedge clk);
      if (!da && awr === 1'b1) begin
        da = 1;
        awv <= 1'b0;
      end
      if (!dw && wr === 1'b1) begin
        dw = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    chk("BRESP", e, br);
    bry <= 1'b0;
    // Idle edge between transfers
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdat;
    chk("RRESP", e, rr);
    rry <= 1'b0;
    // Idle edge between transfers
    @(posedge clk);
  endtask
  task automatic t_regs();
    rd_reg(REG_CTRL, d, RESP_OKAY);
    chk("CTRL", CTRL_RESET, d);
    rd_reg(8'h10, d, RESP_OKAY);
    chk("CFG0", CFG_RESET, d);
    rd_reg(8'h08, d, RESP_DECERR);
    chk("UNMAPPED", 32'h0, d);
    wr_reg(8'h08, 32'hFFFF_FFFF, RESP_DECERR);
    wr_reg(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    wr_reg(8'h1C, 32'h0004_0100, RESP_OKAY);
    rd_reg(8'h1C, d, RESP_OKAY);
    chk("CFG1", 32'h0004_0100, d);
    $display("t_regs done");
  endtask
  task automatic t_single();
    clr();
    wr_reg(REG_CTRL, 32'h1, RESP_OKAY);
    repeat (30) @(posedge clk);
    for (int i = 0; i < 4; i++) chk("SINGLE_ORDER", i, log_q[i]);
    repeat (100) @(posedge clk);
    for (int i = 0; i < 4; i++) chk("SINGLE_COUNT", 1, cnt[i]);
    rd_reg(REG_STATUS, d, RESP_OKAY);
    chk("STATUS", 32'h010F_0000, d & 32'hFFFF_FFF0);
    $display("t_single done");
  endtask
  task automatic t_cyclic();
    wr_reg(8'h10, 32'h0002_2301, RESP_OKAY);
    repeat (100) @(posedge clk);
    chk("CYCLIC_GAP", 2 * TK, gap0);
    $display("t_cyclic done");
  endtask
  task automatic t_data();
    wr_reg(8'h18, 32'h0001_2202, RESP_OKAY);
    clr();
    repeat (40) @(posedge clk);
    chk("DATA_IDLE", 0, cnt[1]);
    ctl.put(12'h103, 8'h5A);
    repeat (40) @(posedge clk);
    chk("DATA_HIT", 1, cnt[1]);
    ctl.put(12'h104, 8'h5A);
    ctl.put(12'h220, 8'h01);
    repeat (40) @(posedge clk);
    chk("DATA_MISS", 1, cnt[1]);
    $display("t_data done");
  endtask
  task automatic t_trig();
    int n;
    wr_reg(8'h20, 32'h0003_2103, RESP_OKAY);
    wr_reg(8'h28, 32'h0001_1F03, RESP_OKAY);
    rd_reg(REG_STATUS, d, RESP_OKAY);
    chk("CFG_ERR", 32'h010F_0800, d & 32'hFFFF_FFF0);
    clr();
    ctl.post(12'h200, 8'h11, 12'h210, 8'h01);
    repeat (70) @(posedge clk);
    chk("TRIG_ONE", 1, cnt[2]);
    // Both increments just after a tick, so one interval sees both
    n = cnt[0];
    while (cnt[0] == n) @(posedge clk);
    ctl.put(12'h210, 8'h02);
    ctl.put(12'h210, 8'h03);
    repeat (70) @(posedge clk);
    chk("TRIG_ONCE", 2, cnt[2]);
    ctl.put(12'h1F0, 8'h01);
    repeat (70) @(posedge clk);
    chk("TRIG_BAD", 0, cnt[3]);
    // Byte at 0x220 was written while not in trigger mode
    wr_reg(8'h18, 32'h0001_2203, RESP_OKAY);
    repeat (30) @(posedge clk);
    chk("TRIG_IDLE", 0, cnt[1]);
    $display("t_trig done");
  endtask
  task automatic t_fifo();
    // Configure while stopped, so all four fire at the same tick
    wr_reg(REG_CTRL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) wr_reg(8'(16 + 8 * i), 32'h0001_0001, RESP_OKAY);
    trdy <= 1'b0;
    wr_reg(REG_CTRL, 32'h1, RESP_OKAY);
    repeat (100) @(posedge clk);
    chk("FULL_VALID", 1, tv);
    chk("FULL_HEAD", 0, idx);
    clr();
    wr_reg(REG_CTRL, 32'h0, RESP_OKAY);
    trdy <= 1'b1;
    repeat (50) @(posedge clk);
    chk("DRAIN_COUNT", 8, log_q.size());
    for (int i = 0; i < 8; i++) chk("DRAIN_ORDER", i % 4, log_q[i]);
    chk("EMPTY", 0, tv);
    $display("t_fifo done");
  endtask
  task automatic finish_test();
    $display("Compared %0d, mismatched %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_single();
    t_cyclic();
    t_data();
    t_trig();
    t_fifo();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
